// ---- src/labu_pkg.sv ----
// shared constants and types of the likely and coprocessor branch unit
package labu_pkg;

    // ------------------------------------------------------------
    // widths and fixed values
    // ------------------------------------------------------------
    localparam int          LABU_XLEN      = 32;
    localparam int          LABU_OFS_W     = 16;
    localparam int          LABU_OFS_SHIFT = 2;
    localparam int          LABU_REG_W     = 5;
    localparam logic [4:0]  LABU_LINK_IDX  = 5'h1f;
    localparam logic [31:0] LABU_INSN_STEP = 32'h0000_0004;
    localparam logic [31:0] LABU_ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // branch kinds handled here
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LABU_OP_NONE   = 4'b0000,
        LABU_OP_CPT    = 4'b0001,  // cp_true_branch
        LABU_OP_CPF    = 4'b0010,  // cp_false_branch
        LABU_OP_CPTL   = 4'b0011,  // cp_true_branch_likely
        LABU_OP_CPFL   = 4'b0100,  // cp_false_branch_likely
        LABU_OP_EQL    = 4'b0101,  // equal_branch_likely
        LABU_OP_NEL    = 4'b0110,  // unequal_branch_likely
        LABU_OP_LEZL   = 4'b0111,  // nonpositive_branch_likely
        LABU_OP_GTZL   = 4'b1000,  // positive_branch_likely
        LABU_OP_LTZL   = 4'b1001,  // negative_branch_likely
        LABU_OP_GEZL   = 4'b1010,  // nonnegative_branch_likely
        LABU_OP_LTZALL = 4'b1011,  // negative_link_branch_likely
        LABU_OP_GEZALL = 4'b1100   // nonnegative_link_branch_likely
    } labu_op_t;

endpackage

// ---- src/labu_cond_if.sv ----
// carrier between the branch unit and its condition evaluator
`timescale 1ns/1ps
interface labu_cond_if;
    import labu_pkg::*;

    labu_op_t               op;
    logic [LABU_XLEN-1:0]   opa;
    logic [LABU_XLEN-1:0]   opb;
    logic                   cp_cond;
    logic                   take;
    logic                   likely;
    logic                   link;

    modport eval (
        input  op,
        input  opa,
        input  opb,
        input  cp_cond,
        output take,
        output likely,
        output link
    );

    modport user (
        output op,
        output opa,
        output opb,
        output cp_cond,
        input  take,
        input  likely,
        input  link
    );
endinterface

// ---- src/labu_cond.sv ----
// branch condition evaluator: taken, likely and link flags per kind
`timescale 1ns/1ps
module labu_cond (
    labu_cond_if.eval c
);
    import labu_pkg::*;

    // ------------------------------------------------------------
    // sign tests on a two's-complement operand
    // ------------------------------------------------------------
    function automatic logic is_neg(input logic [LABU_XLEN-1:0] v);
        return v[LABU_XLEN-1];
    endfunction

    function automatic logic is_zero(input logic [LABU_XLEN-1:0] v);
        return v == LABU_ZERO_WORD;
    endfunction

    always_comb begin
        c.take   = 1'b0;
        c.likely = 1'b0;
        c.link   = 1'b0;
        unique case (c.op)
            LABU_OP_NONE: begin
            end
            LABU_OP_CPT: c.take = c.cp_cond;
            LABU_OP_CPF: c.take = !c.cp_cond;
            LABU_OP_CPTL: begin
                c.take   = c.cp_cond;
                c.likely = 1'b1;
            end
            LABU_OP_CPFL: begin
                c.take   = !c.cp_cond;
                c.likely = 1'b1;
            end
            LABU_OP_EQL: begin
                c.take   = c.opa == c.opb;
                c.likely = 1'b1;
            end
            LABU_OP_NEL: begin
                c.take   = c.opa != c.opb;
                c.likely = 1'b1;
            end
            LABU_OP_LEZL: begin
                c.take   = is_neg(c.opa) || is_zero(c.opa);
                c.likely = 1'b1;
            end
            LABU_OP_GTZL: begin
                c.take   = !is_neg(c.opa) && !is_zero(c.opa);
                c.likely = 1'b1;
            end
            LABU_OP_LTZL: begin
                c.take   = is_neg(c.opa);
                c.likely = 1'b1;
            end
            LABU_OP_GEZL: begin
                c.take   = !is_neg(c.opa);
                c.likely = 1'b1;
            end
            LABU_OP_LTZALL: begin
                c.take   = is_neg(c.opa);
                c.likely = 1'b1;
                c.link   = 1'b1;
            end
            LABU_OP_GEZALL: begin
                c.take   = !is_neg(c.opa);
                c.likely = 1'b1;
                c.link   = 1'b1;
            end
            // codes above the last kind carry no branch
            default: begin
            end
        endcase
    end
endmodule

// ---- src/labu_branch_unit.sv ----
// likely and coprocessor condition branch resolution unit
`timescale 1ns/1ps
module labu_branch_unit (
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic                              ce,
    input  wire logic                              issue_valid,
    input  wire labu_pkg::labu_op_t                issue_op,
    input  wire logic [labu_pkg::LABU_XLEN-1:0]    delay_pc,
    input  wire logic [labu_pkg::LABU_OFS_W-1:0]   offset,
    input  wire logic [labu_pkg::LABU_XLEN-1:0]    primary_operand_reg,
    input  wire logic [labu_pkg::LABU_XLEN-1:0]    second_operand_reg,
    input  wire logic                              cp_cond,
    output logic                                   redirect_r,
    output logic [labu_pkg::LABU_XLEN-1:0]         target_r,
    output logic                                   annul_r,
    output logic                                   link_we_r,
    output logic [labu_pkg::LABU_REG_W-1:0]        link_idx_r,
    output logic [labu_pkg::LABU_XLEN-1:0]         link_addr_r
);
    import labu_pkg::*;

    // ------------------------------------------------------------
    // condition evaluation
    // ------------------------------------------------------------
    labu_cond_if cif ();

    assign cif.op      = issue_valid ? issue_op : LABU_OP_NONE;
    assign cif.opa     = primary_operand_reg;
    assign cif.opb     = second_operand_reg;
    assign cif.cp_cond = cp_cond;

    labu_cond u_cond (
        .c (cif)
    );

    // ------------------------------------------------------------
    // resolution, registered into the execute stage
    // ------------------------------------------------------------
    logic                   redirect_nxt;
    logic [LABU_XLEN-1:0]   target_nxt;
    logic                   annul_nxt;
    logic                   link_we_nxt;
    logic [LABU_REG_W-1:0]  link_idx_nxt;
    logic [LABU_XLEN-1:0]   link_addr_nxt;
    logic [LABU_XLEN-1:0]   ofs_ext;

    always_comb begin
        // offset scaled to words, sign carried to the full width
        ofs_ext       = LABU_XLEN'($signed(offset)) << LABU_OFS_SHIFT;
        target_nxt    = delay_pc + ofs_ext;
        redirect_nxt  = cif.take;
        // plain forms leave annul low, so their slot always runs
        annul_nxt     = cif.likely && !cif.take;
        // link ignores take: written even when the slot is annulled
        link_we_nxt   = cif.link;
        link_idx_nxt  = LABU_LINK_IDX;
        link_addr_nxt = delay_pc + LABU_INSN_STEP;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            redirect_r  <= 1'b0;
            target_r    <= LABU_ZERO_WORD;
            annul_r     <= 1'b0;
            link_we_r   <= 1'b0;
            link_idx_r  <= LABU_LINK_IDX;
            link_addr_r <= LABU_ZERO_WORD;
        end else if (ce) begin
            redirect_r  <= redirect_nxt;
            target_r    <= target_nxt;
            annul_r     <= annul_nxt;
            link_we_r   <= link_we_nxt;
            link_idx_r  <= link_idx_nxt;
            link_addr_r <= link_addr_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_issue(labu_op_t k);
        ce && issue_valid && issue_op == k;
    endsequence

    sequence s_taken_no_annul;
        redirect_r && !annul_r;
    endsequence

    sequence s_annul_only;
        !redirect_r && annul_r;
    endsequence

    a_cpt_target: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_CPT) ##0 cp_cond |=> s_taken_no_annul
            ##0 target_r == $past(delay_pc)
                + (LABU_XLEN'($signed($past(offset))) << LABU_OFS_SHIFT))
        else $error("cop-true branch target or redirect wrong");

    a_cpf_taken: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_CPF) |=> redirect_r == !$past(cp_cond) && !annul_r)
        else $error("cop-false branch resolved wrong");

    a_cptl_annul: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_CPTL) ##0 !cp_cond |=> s_annul_only)
        else $error("cop-true likely did not annul slot");

    a_cpfl_annul: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_CPFL) |=> annul_r == $past(cp_cond)
            && redirect_r == !$past(cp_cond))
        else $error("cop-false likely resolved wrong");

    a_eql_resolve: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_EQL) |=> redirect_r == ($past(primary_operand_reg)
            == $past(second_operand_reg)) && annul_r == !redirect_r)
        else $error("equal likely resolved wrong");

    a_nel_resolve: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_NEL) ##0 primary_operand_reg == second_operand_reg
            |=> s_annul_only)
        else $error("unequal likely did not annul on equal");

    a_lezl_zero: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_LEZL) ##0 primary_operand_reg == LABU_ZERO_WORD
            |=> s_taken_no_annul)
        else $error("nonpositive likely missed zero");

    a_gtzl_zero: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_GTZL) ##0 primary_operand_reg == LABU_ZERO_WORD
            |=> s_annul_only)
        else $error("positive likely took zero");

    a_sign_bit: assert property (@(posedge core_clk) disable iff (rst)
        s_issue(LABU_OP_LTZL) |=> redirect_r
            == $past(primary_operand_reg[LABU_XLEN-1]))
        else $error("negative likely ignored sign bit");

    a_link_always: assert property (@(posedge core_clk) disable iff (rst)
        (s_issue(LABU_OP_LTZALL) or s_issue(LABU_OP_GEZALL)) |=> link_we_r
            && link_idx_r == LABU_LINK_IDX
            && link_addr_r == $past(delay_pc) + LABU_INSN_STEP)
        else $error("link write missing or wrong");

    a_plain_slot: assert property (@(posedge core_clk) disable iff (rst)
        (s_issue(LABU_OP_CPT) or s_issue(LABU_OP_CPF)) |=> !annul_r
            && !link_we_r)
        else $error("plain branch annulled its slot");

    a_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
        ce && !issue_valid |=> !redirect_r && !annul_r && !link_we_r)
        else $error("outputs active without a branch");
endmodule

// ---- verif/labu_cp_model.sv ----
// coprocessor condition source facing the branch unit
`timescale 1ns/1ps
module labu_cp_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      cp_cond
);
    // ------------------------------------------------------------
    // condition pattern
    // ------------------------------------------------------------
    logic [7:0] lfsr_r;
    logic [1:0] hold_r;

    // slow mode keeps the flag for four cycles, prompt mode every cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lfsr_r <= 8'h5a;
            hold_r <= 2'h0;
        end else begin
            hold_r <= hold_r + 2'h1;
            if (!slow || hold_r == 2'h3) begin
                lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4]
                           ^ lfsr_r[3]};
            end
        end
    end

    assign cp_cond = lfsr_r[0];
endmodule

// ---- verif/test_labu_branch_unit.sv ----
// self-checking testbench of the likely and coprocessor branch unit
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_labu_branch_unit;
    import labu_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b0;
    logic        issue_valid = 1'b0;
    logic        slow = 1'b0;
    labu_op_t    issue_op = LABU_OP_NONE;
    logic [31:0] delay_pc = 32'h0000_0000;
    logic [15:0] offset = 16'h0000;
    logic [31:0] primary_operand_reg = 32'h0000_0000;
    logic [31:0] second_operand_reg = 32'h0000_0000;
    wire         cp_cond;
    logic        redirect_r;
    logic        annul_r;
    logic        link_we_r;
    logic [31:0] target_r;
    logic [31:0] link_addr_r;
    logic [4:0]  link_idx_r;
    logic        e_red, e_ann, e_lwe, chk_on = 1'b0;
    logic [31:0] e_tgt, e_laddr, a;
    logic [2:0]  f;
    logic [3:0]  opn;
    int          fails = 0, compares = 0, cycles = 0;
    logic [31:0] corner [6] = '{32'h0000_0000, 32'h0000_0001,
        32'hffff_ffff, 32'h8000_0000, 32'h7fff_ffff, 32'hffff_fffe};

    always #12.5 core_clk = ~core_clk;

    labu_cp_model i_cp (.core_clk(core_clk), .rst(rst), .slow(slow),
                        .cp_cond(cp_cond));

    labu_branch_unit i_dut (
        .core_clk(core_clk), .rst(rst), .ce(ce),
        .issue_valid(issue_valid), .issue_op(issue_op),
        .delay_pc(delay_pc), .offset(offset),
        .primary_operand_reg(primary_operand_reg),
        .second_operand_reg(second_operand_reg), .cp_cond(cp_cond),
        .redirect_r(redirect_r), .target_r(target_r), .annul_r(annul_r),
        .link_we_r(link_we_r), .link_idx_r(link_idx_r),
        .link_addr_r(link_addr_r));

    // ------------------------------------------------------------
    // reference: {taken, annul, link} per kind
    // ------------------------------------------------------------
    function automatic logic [2:0] exp_flags(labu_op_t op, logic [31:0] x,
                                             logic [31:0] y, logic c);
        logic t, lk, ln, neg, zer;
        neg = x[31];
        zer = (x == 32'h0000_0000);
        t = 1'b0;
        lk = 1'b1;
        ln = 1'b0;
        case (op)
            LABU_OP_CPT:    begin t = c; lk = 1'b0; end
            LABU_OP_CPF:    begin t = !c; lk = 1'b0; end
            LABU_OP_CPTL:   t = c;
            LABU_OP_CPFL:   t = !c;
            LABU_OP_EQL:    t = (x == y);
            LABU_OP_NEL:    t = (x != y);
            LABU_OP_LEZL:   t = neg | zer;
            LABU_OP_GTZL:   t = !neg & !zer;
            LABU_OP_LTZL:   t = neg;
            LABU_OP_GEZL:   t = !neg;
            LABU_OP_LTZALL: begin t = neg; ln = 1'b1; end
            LABU_OP_GEZALL: begin t = !neg; ln = 1'b1; end
            default:        lk = 1'b0;
        endcase
        return {t, lk & !t, ln};
    endfunction

    always @(posedge core_clk) begin
        chk_on <= 1'b1;
        if (rst) begin
            {e_red, e_ann, e_lwe} <= 3'h0;
            e_tgt <= 32'h0000_0000;
            e_laddr <= 32'h0000_0000;
        end else if (ce) begin
            f = exp_flags(issue_op, primary_operand_reg, second_operand_reg,
                          cp_cond);
            {e_red, e_ann, e_lwe} <= issue_valid ? f : 3'h0;
            e_tgt <= delay_pc + {{14{offset[15]}}, offset, 2'b00};
            e_laddr <= delay_pc + LABU_INSN_STEP;
        end
    end

    always @(negedge core_clk) begin
        if (chk_on) begin
            `CHK(redirect_r, e_red)
            `CHK(annul_r, e_ann)
            `CHK(link_we_r, e_lwe)
            `CHK(target_r, e_tgt)
            `CHK(link_idx_r, LABU_LINK_IDX)
            `CHK(link_addr_r, e_laddr)
        end
    end

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard well above the planned 2023 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // stimulus: op sweep over corner operands, then random traffic
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hc12ae2f8));
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 2000; i++) begin
            @(posedge core_clk);
            opn = (i < 208) ? 4'(i % 13) : 4'($urandom % 16);
            a = (i < 208 || i % 3 == 0) ? corner[$urandom % 6] : $urandom;
            ce <= (i < 208) || ($urandom % 8 != 0);
            issue_valid <= (i < 208) || ($urandom % 4 != 0);
            issue_op <= labu_op_t'(opn);
            primary_operand_reg <= a;
            second_operand_reg <= ($urandom % 2) ? a : $urandom;
            delay_pc <= {$urandom, 2'b00} >> 2 << 2;
            offset <= (i % 5 == 0) ? 16'h8000 : 16'($urandom);
            slow <= (i > 1000);
            if (i == 900) begin
                rst <= 1'b1;
            end
            if (i == 903) begin
                rst <= 1'b0;
            end
        end
        repeat (3) @(posedge core_clk);
        stop_test();
    end
endmodule
